// ==== rtl/eep_slave.sv ====
// How it works
// - Address byte accepted only when upper four bits match class 1010.
// - Address byte bit zero: one means read, zero means write.
// - Receiver pulls data low on ninth clock to acknowledge a byte.
// - In write mode every received byte is acknowledged while write protect is low.
// - Read: send eight bits, release, sample master acknowledge, continue or stop.
// - STOP after write launches programming; all requests ignored meanwhile.
// - One page write holds up to sixty-four data bytes.
// - Each written byte advances only the low six address bits.
// - Extra bytes wrap within page and overwrite earlier buffered ones.
// - All buffered bytes are programmed together, started by STOP.
// - Address byte unacknowledged while programming, acknowledged afterwards.
// - Write protect high: addresses acknowledged, first data byte refused.
// - Counter holds last location plus one; current read uses it.
// - Counter wraps from top location to zero during reads.
// - Each master acknowledge fetches the next byte; none ends it.
// - Read counter increments across its full fourteen bits.
// - SDA falling with SCL high is START, rising is STOP.
// - Programming lasts ten milliseconds; bus released meanwhile.
// - Write protect low allows writes to the whole array.
`default_nettype none
module eep_slave #(
  parameter int WR_CYC = eep_pkg::WR_CYCLES // Programming time in cycles
) (
  input wire logic sys_clk, // System clock, 200 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Bus data pin, resolved level
  input wire logic wp_i, // Write protect pin
  output logic sda_o, // Bus data drive value, always low
  output logic sda_oe, // Bus data pull-down enable
  output logic busy // Programming cycle in progress
);
  import eep_pkg::*;

  typedef struct packed {
    eep_state_type state;
    logic [3:0] bit_cnt;
    logic [1:0] kind;
    logic [7:0] shreg;
    logic rw;
    logic [ADDR_W-1:0] addr;
    logic [HI_USED-1:0] hi;
    logic mack;
    logic wr_pend;
    logic busy;
    logic [TMR_W-1:0] tmr;
    logic sda_oe;
    logic sda_o;
    eep_buf_wr_type wr;
    logic commit;
  } eep_slave_type;

  eep_slave_type st;
  eep_slave_type next_st;
  eep_bus_type bus;
  logic [7:0] rdata;
  logic [1:0] rst_pipe;
  logic rst_sync_n;

  // Class match on a received address byte
  function automatic logic eep_class_hit(input logic [7:0] b);
    eep_class_hit = (b[7:CLASS_LSB] == DEV_CLASS);
  endfunction

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe[1];

  // Pin conditioning and event detection
  eep_sync u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .wp_i(wp_i),
    .bus(bus)
  );

  // Page buffer and array
  eep_store u_store (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_n),
    .wr(st.wr),
    .commit(st.commit),
    .raddr(st.addr),
    .rdata(rdata)
  );

  // Protocol engine and programming timer
  always_comb begin
    next_st = st;
    next_st.wr.we = 1'b0;
    next_st.commit = 1'b0;
    next_st.sda_o = 1'b0;

    // Programming timer; bus ignored until it expires
    if (st.busy) begin
      if (st.tmr == TMR_W'(WR_CYC - 1)) begin
        next_st.busy = 1'b0;
        next_st.tmr = TMR_RESET;
      end else begin
        next_st.tmr = st.tmr + 21'h1;
      end
    end

    if (bus.stop) begin
      // STOP abandons any transfer and may launch programming
      next_st.state = EEP_IDLE;
      next_st.sda_oe = 1'b0;
      if (st.wr_pend && !st.busy) begin
        next_st.busy = 1'b1;
        next_st.tmr = TMR_RESET;
        next_st.commit = 1'b1;
        next_st.wr_pend = 1'b0;
      end
    end else if (bus.start) begin
      // START, also repeated, begins address reception
      next_st.state = EEP_RX;
      next_st.bit_cnt = 4'h0;
      next_st.kind = KIND_DEV;
      next_st.sda_oe = 1'b0;
    end else begin
      case (st.state)
        EEP_IDLE: begin
          next_st.sda_oe = 1'b0;
        end
        EEP_RX: begin
          if (bus.scl_rise && st.bit_cnt != BYTE_BITS) begin
            next_st.shreg = {st.shreg[6:0], bus.sda};
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          end else if (bus.scl_fall && st.bit_cnt == BYTE_BITS) begin
            next_st.bit_cnt = 4'h0;
            next_st.state = EEP_ACK;
            next_st.sda_oe = 1'b1;
            case (st.kind)
              KIND_DEV: begin
                if (eep_class_hit(st.shreg) && !st.busy) begin
                  next_st.rw = st.shreg[RW_BIT];
                  next_st.kind = KIND_HI;
                end else begin
                  next_st.state = EEP_IDLE;
                  next_st.sda_oe = 1'b0;
                end
              end
              KIND_HI: begin
                next_st.hi = st.shreg[HI_USED-1:0];
                next_st.kind = KIND_LO;
              end
              KIND_LO: begin
                next_st.addr = {st.hi, st.shreg};
                next_st.kind = KIND_DATA;
              end
              default: begin
                if (bus.wp) begin
                  next_st.state = EEP_IDLE;
                  next_st.sda_oe = 1'b0;
                end else begin
                  next_st.wr.we = 1'b1;
                  next_st.wr.idx = st.addr[PAGE_W-1:0];
                  next_st.wr.data = st.shreg;
                  next_st.wr.page = st.addr[ADDR_W-1:PAGE_W];
                  next_st.wr_pend = 1'b1;
                  next_st.addr = {st.addr[ADDR_W-1:PAGE_W],
                    st.addr[PAGE_W-1:0] + 6'h1};
                end
              end
            endcase
          end
        end
        EEP_ACK: begin
          if (bus.scl_fall) begin
            if (st.rw) begin
              // Start first data bit right after the acknowledge
              next_st.state = EEP_TX;
              next_st.shreg = rdata;
              next_st.sda_oe = ~rdata[7];
              next_st.bit_cnt = 4'h0;
            end else begin
              next_st.state = EEP_RX;
              next_st.sda_oe = 1'b0;
            end
          end
        end
        EEP_TX: begin
          if (bus.scl_fall) begin
            if (st.bit_cnt == LAST_TX_BIT) begin
              next_st.sda_oe = 1'b0;
              next_st.state = EEP_MACK;
              next_st.mack = 1'b0;
              next_st.addr = st.addr + 14'h1;
            end else begin
              next_st.shreg = {st.shreg[6:0], 1'b0};
              next_st.sda_oe = ~st.shreg[6];
              next_st.bit_cnt = st.bit_cnt + 4'h1;
            end
          end
        end
        EEP_MACK: begin
          if (bus.scl_rise) begin
            next_st.mack = ~bus.sda;
          end else if (bus.scl_fall) begin
            if (st.mack) begin
              next_st.state = EEP_TX;
              next_st.shreg = rdata;
              next_st.sda_oe = ~rdata[7];
              next_st.bit_cnt = 4'h0;
            end else begin
              next_st.state = EEP_IDLE;
              next_st.sda_oe = 1'b0;
            end
          end
        end
        default: begin
          next_st.state = EEP_IDLE;
          next_st.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= '0;
      st.state <= EEP_IDLE;
      st.addr <= ADDR_RESET;
      st.tmr <= TMR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign sda_o = st.sda_o;
  assign sda_oe = st.sda_oe;
  assign busy = st.busy;
endmodule
`default_nettype wire

// ==== rtl/eep_pkg.sv ====
`default_nettype none
package eep_pkg;
  // Clock rate and programming time
  localparam int CLK_MHZ = 200;
  localparam int WR_TIME_MS = 10;
  // Longest time, rounds down (exact here)
  localparam int WR_CYCLES = WR_TIME_MS * 1000 * CLK_MHZ;
  localparam int TMR_W = 21;

  // Array and page geometry
  localparam int ADDR_W = 14;
  localparam int MEM_DEPTH = 16384;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int HI_USED = 6;

  // Device address byte layout
  localparam logic [3:0] DEV_CLASS = 4'ha;
  localparam int CLASS_LSB = 4;
  localparam int RW_BIT = 0;

  // Bit counting
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;

  // Which byte of a transfer is being received
  localparam logic [1:0] KIND_DEV = 2'h0;
  localparam logic [1:0] KIND_HI = 2'h1;
  localparam logic [1:0] KIND_LO = 2'h2;
  localparam logic [1:0] KIND_DATA = 2'h3;

  // Reset values
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [13:0] ADDR_RESET = 14'h0000;
  localparam logic [TMR_W-1:0] TMR_RESET = 21'h000000;

  // Protocol states, Gray coded along the usual path
  typedef enum logic [2:0] {
    EEP_IDLE = 3'h0,
    EEP_RX = 3'h1,
    EEP_ACK = 3'h3,
    EEP_TX = 3'h2,
    EEP_MACK = 3'h6
  } eep_state_type;

  // Conditioned bus events
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
    logic wp;
  } eep_bus_type;

  // Page buffer write port
  typedef struct packed {
    logic we;
    logic [PAGE_W-1:0] idx;
    logic [7:0] data;
    logic [ADDR_W-PAGE_W-1:0] page;
  } eep_buf_wr_type;
endpackage
`default_nettype wire

// ==== rtl/eep_sync.sv ====
`default_nettype none
module eep_sync (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Bus data pin level
  input wire logic wp_i, // Write protect pin
  output eep_pkg::eep_bus_type bus // Conditioned events
);
  import eep_pkg::*;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic scl_d;
    logic sda_d;
    eep_bus_type bus;
  } eep_sync_type;

  eep_sync_type st;
  eep_sync_type next_st;

  // Two stages, then edge and condition detection on second stage
  always_comb begin
    next_st = st;
    next_st.meta = {scl_i, sda_i, wp_i};
    next_st.sync = st.meta;
    next_st.scl_d = st.sync[2];
    next_st.sda_d = st.sync[1];
    next_st.bus.scl_rise = st.sync[2] & ~st.scl_d;
    next_st.bus.scl_fall = ~st.sync[2] & st.scl_d;
    next_st.bus.start = st.sync[2] & st.scl_d & st.sda_d & ~st.sync[1];
    next_st.bus.stop = st.sync[2] & st.scl_d & ~st.sda_d & st.sync[1];
    next_st.bus.sda = st.sync[1];
    next_st.bus.wp = st.sync[0];
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.meta <= {LINE_IDLE, LINE_IDLE, 1'b0};
      st.sync <= {LINE_IDLE, LINE_IDLE, 1'b0};
      st.scl_d <= LINE_IDLE;
      st.sda_d <= LINE_IDLE;
      st.bus.sda <= LINE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign bus = st.bus;
endmodule
`default_nettype wire

// ==== rtl/eep_store.sv ====
`default_nettype none
module eep_store #(
  parameter int DEPTH = eep_pkg::MEM_DEPTH, // Array bytes
  parameter int PBYTES = eep_pkg::PAGE_BYTES // Page buffer bytes
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire eep_pkg::eep_buf_wr_type wr, // Page buffer write
  input wire logic commit, // Launch array programming
  input wire logic [eep_pkg::ADDR_W-1:0] raddr, // Read address
  output logic [7:0] rdata // Registered read data
);
  import eep_pkg::*;

  typedef struct packed {
    logic [PBYTES-1:0] valid;
    logic [ADDR_W-PAGE_W-1:0] page;
    logic walking;
    logic [PAGE_W-1:0] widx;
    logic [7:0] rdata;
  } eep_store_type;

  logic [7:0] mem [DEPTH];
  logic [7:0] pbuf [PBYTES];
  eep_store_type st;
  eep_store_type next_st;

  // Buffer fill, then one walk copies all valid bytes to the array
  always_comb begin
    next_st = st;
    next_st.rdata = mem[raddr];
    if (wr.we) begin
      next_st.valid[wr.idx] = 1'b1;
      next_st.page = wr.page;
    end
    if (commit) begin
      next_st.walking = 1'b1;
      next_st.widx = '0;
    end else if (st.walking) begin
      next_st.valid[st.widx] = 1'b0;
      next_st.widx = st.widx + 6'h1;
      if (st.widx == 6'h3f) begin
        next_st.walking = 1'b0;
      end
    end
  end

  // Buffer storage, later bytes overwrite earlier ones
  always_ff @(posedge sys_clk) begin
    if (wr.we) begin
      pbuf[wr.idx] <= wr.data;
    end
  end

  // Array programming
  always_ff @(posedge sys_clk) begin
    if (st.walking && st.valid[st.widx]) begin
      mem[{st.page, st.widx}] <= pbuf[st.widx];
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
endmodule
`default_nettype wire

// ==== verification/eep_slave_props.sv ====
`default_nettype none
module eep_slave_props #(
  parameter int WR_CYC = 200 // Programming time in cycles
) (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic scl_i, // Bus clock pin
  input wire logic sda_i, // Bus data level
  input wire logic wp_i, // Write protect pin
  input wire logic sda_o, // Drive value
  input wire logic sda_oe, // Pull-down enable
  input wire logic busy // Programming flag
);
  logic scl_q;
  logic sda_q;
  logic [31:0] bcnt;
  logic [3:0] stop_age;
  // Busy length and cycles since a stop on the pins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bcnt <= 32'h0;
      stop_age <= 4'hf;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      bcnt <= busy ? bcnt + 32'h1 : 32'h0;
      if (scl_i && scl_q && sda_i && !sda_q) begin
        stop_age <= 4'h0;
      end else if (stop_age != 4'hf) begin
        stop_age <= stop_age + 4'h1;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  pull_only_a: assert property (sda_oe |-> !sda_o)
    else $error("drive value not low");
  busy_quiet_a: assert property (busy |-> !sda_oe)
    else $error("data driven while programming");
  busy_len_a: assert property (bcnt <= WR_CYC)
    else $error("programming too long");
  scl_low_change_a: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data changed with clock high");
  stop_launch_a: assert property ($rose(busy) |-> stop_age <= 4'ha)
    else $error("programming without stop");
  wp_block_a: assert property ($rose(busy) |-> !wp_i)
    else $error("programming while protected");
  start_release_a: assert property (
    scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:8] !sda_oe)
    else $error("data held after start");
  ack_stand_a: assert property (
    $rose(sda_oe) |-> !scl_i ##1 sda_oe [*8])
    else $error("drive too short");
endmodule
bind eep_slave eep_slave_props #(.WR_CYC(WR_CYC)) props_u (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .wp_i(wp_i),
  .sda_o(sda_o),
  .sda_oe(sda_oe),
  .busy(busy)
);
`default_nettype wire

// ==== verification/eep_master.sv ====
`default_nettype none
module eep_master (
  input wire logic sys_clk, // System clock for pacing
  input wire logic sda, // Resolved data line
  output var logic scl, // Bus clock
  output var logic sda_low // High pulls data low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idles released with clock high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One clock: data set while low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    q(3);
    sda_low <= !b;
    q(3);
    scl <= 1'b1;
    q(3);
    #1;
    r = sda;
    q(4);
    scl <= 1'b0;
  endtask
  // Start or repeated start; waits out an acknowledge still held
  task automatic start;
    sda_low <= 1'b0;
    q(6);
    scl <= 1'b1;
    q(3);
    sda_low <= 1'b1;
    q(3);
    scl <= 1'b0;
  endtask
  // Every operation closes with a stop
  task automatic stop;
    sda_low <= 1'b1;
    q(6);
    scl <= 1'b1;
    q(3);
    sda_low <= 1'b0;
    q(3);
  endtask
  // Byte out MSB first, then sample the ninth clock
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then acknowledge or withhold it
  task automatic recv(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, r);
      d = {d[6:0], r};
    end
    bit_io(!mack, r);
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_serial_eeprom_slave_access.sv ====
`default_nettype none
module tb_serial_eeprom_slave_access;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_i = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_o;
  logic sda_oe;
  logic busy;
  wire logic sda = !sda_low && !sda_oe;
  int err_total = 0;
  int checked = 0;
  always #2.5 sys_clk = !sys_clk;
  eep_slave #(.WR_CYC(200)) dut_u (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .scl_i(scl),
    .sda_i(sda),
    .wp_i(wp_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .busy(busy)
  );
  eep_master m_u (
    .sys_clk(sys_clk),
    .sda(sda),
    .scl(scl),
    .sda_low(sda_low)
  );
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string w);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, w);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: read %h not %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] b, input logic exp);
    logic a;
    m_u.send(b, a);
    cmp_bit(a, exp, "acknowledge");
  endtask
  task automatic rd(input logic [7:0] exp, input logic mack);
    logic [7:0] d;
    m_u.recv(mack, d);
    cmp_byte(d, exp);
  endtask
  // Bounded acknowledge polling after a write
  task automatic poll;
    logic a;
    for (int i = 0; i < 40; i++) begin
      m_u.start();
      m_u.send(8'ha0, a);
      m_u.stop();
      if (a === 1'b1) return;
    end
    cmp_bit(1'b0, 1'b1, "poll limit");
    print_verdict();
  endtask
  task automatic rd_setup(input logic [7:0] hi, input logic [7:0] lo);
    m_u.start();
    xfer(8'ha0, 1'b1);
    xfer(hi, 1'b1);
    xfer(lo, 1'b1);
    m_u.start();
    xfer(8'ha1, 1'b1);
  endtask
  // Two bytes at zero, upper address bits set but ignored
  task automatic t_write_poll;
    m_u.start();
    xfer(8'ha0, 1'b1);
    xfer(8'hc0, 1'b1);
    xfer(8'h00, 1'b1);
    xfer(8'h11, 1'b1);
    xfer(8'h22, 1'b1);
    m_u.stop();
    repeat (4) @(posedge sys_clk);
    #1;
    cmp_bit(busy, 1'b1, "busy after stop");
    cmp_bit(sda_o, 1'b0, "drive value");
    m_u.start();
    xfer(8'ha0, 1'b0);
    m_u.stop();
    poll();
    $display("write and poll done");
  endtask
  // Three bytes from 0x3ffe wrap inside the page
  task automatic t_page_wrap;
    m_u.start();
    xfer(8'ha0, 1'b1);
    xfer(8'h3f, 1'b1);
    xfer(8'hfe, 1'b1);
    xfer(8'h33, 1'b1);
    xfer(8'h44, 1'b1);
    xfer(8'h55, 1'b1);
    m_u.stop();
    poll();
    $display("page wrap done");
  endtask
  task automatic t_reads;
    rd_setup(8'h3f, 8'hfe);
    rd(8'h33, 1'b1);
    rd(8'h44, 1'b1);
    rd(8'h11, 1'b0);
    m_u.stop();
    m_u.start();
    xfer(8'ha1, 1'b1);
    rd(8'h22, 1'b0);
    m_u.stop();
    rd_setup(8'h3f, 8'hc0);
    rd(8'h55, 1'b0);
    m_u.stop();
    $display("reads done");
  endtask
  task automatic t_protect;
    wp_i <= 1'b1;
    m_u.start();
    xfer(8'ha0, 1'b1);
    xfer(8'h00, 1'b1);
    xfer(8'h00, 1'b1);
    xfer(8'h77, 1'b0);
    m_u.stop();
    wp_i <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    cmp_bit(busy, 1'b0, "busy when protected");
    rd_setup(8'h00, 8'h00);
    rd(8'h11, 1'b0);
    m_u.stop();
    $display("protect done");
  endtask
  task automatic t_class;
    m_u.start();
    xfer(8'h50, 1'b0);
    m_u.stop();
    m_u.start();
    xfer(8'hae, 1'b1);
    m_u.stop();
    $display("address class done");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    t_write_poll();
    t_page_wrap();
    t_reads();
    t_protect();
    t_class();
    print_verdict();
  end
  // Guard against a hang
  initial begin
    repeat (100000) @(posedge sys_clk);
    cmp_bit(1'b0, 1'b1, "run limit");
    print_verdict();
  end
endmodule
`default_nettype wire
